//--- tb.sv
module tb
  import tsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LIMIT = 80000;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic scl;
  logic sda_drv;
  logic sda_in;
  logic sda_out;
  logic sda_oe_n;
  logic [31:0] raw_delta = 32'h0;
  logic [31:0] base_raw = 32'h0;
  logic [1:0] active_en = 2'b01;
  logic [1:0] lf_noise = 2'b00;
  logic [15:0] touch_thresh = 16'h1414;
  logic [7:0] noise_thresh = 8'h0A;
  logic [1:0] hold_expired = 2'b00;
  logic [15:0] delta_out;
  logic [31:0] base_view;
  logic [1:0] touch;
  logic [1:0] recal_feed;
  logic [1:0] recal_restart;
  logic bus_reset;
  logic [7:0] e;
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;
  int pulses = 0;
  // ----
  // open-drain data line with pull-up
  // ----
  assign sda_in = sda_drv & (sda_oe_n | sda_out);
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (bus_reset === 1'b1) begin
      pulses++;
    end
    if (cyc == LIMIT) begin
      fails++;
      finish_test();
    end
  end
  tsc_host u_host (.clk(clk), .sda_line(sda_in), .scl(scl), .sda_drv(sda_drv));
  tsc_top #(.CH(2), .LOW_CYC(200), .IDLE_CYC(50)) dut (
    .clk(clk), .nrst(nrst), .scl_in(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .raw_delta(raw_delta), .base_raw(base_raw), .active_en(active_en), .lf_noise(lf_noise),
    .touch_thresh(touch_thresh), .noise_thresh(noise_thresh), .hold_expired(hold_expired),
    .delta_out(delta_out), .base_view(base_view), .touch(touch), .recal_feed(recal_feed),
    .recal_restart(recal_restart), .bus_reset(bus_reset)
  );
  // ----
  // tasks
  // ----
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    tests_run++;
    if (got !== ex) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    u_host.wr_reg(a, d, ok);
    chk("write ack", 16'h0001, {15'h0, ok});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] ex);
    logic ok;
    logic [7:0] d;
    u_host.rd_reg(a, d, ok);
    chk("read ack", 16'h0001, {15'h0, ok});
    chk("read data", {8'h0, ex}, {8'h0, d});
  endtask : rd
  // outputs lag the sample by one clock; three leave margin
  task automatic sense(input logic [7:0] ed, input logic et, input logic ef);
    repeat (3) @(negedge clk);
    chk("delta", {8'h0, ed}, {8'h0, delta_out[7:0]});
    chk("touch", {15'h0, et}, {15'h0, touch[0]});
    chk("recal feed", {15'h0, ef}, {15'h0, recal_feed[0]});
  endtask : sense
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test
  // ----
  // sequence
  // ----
  initial begin
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    rd(ADDR_SENS, RST_SENS);
    rd(ADDR_CFG, RST_CFG);
    rd(ADDR_CFG2, RST_CFG2);
    sense(8'h00, 1'b0, 1'b1);
    $display("done: reset values");
    wr(ADDR_SENS, 8'hFF);
    rd(ADDR_SENS, 8'h7F);
    wr(ADDR_CFG2, 8'hFF);
    rd(ADDR_CFG2, 8'h7F);
    wr(ADDR_CFG, 8'h47);
    rd(ADDR_CFG, 8'h00);
    wr(8'h30, 8'h55);
    rd(8'h30, 8'h00);
    $display("done: unused bits");
    raw_delta = {16'h0400, 16'h0400};
    base_raw = {16'h0000, 16'hFFFF};
    for (int i = 0; i < 16; i++) begin
      wr(ADDR_SENS, {1'b0, i[2:0], i[3:0]});
      e = (i[2:0] < 3'd4) ? 8'h7F : 8'h40 >> (i[2:0] - 3'd4);
      sense(e, e >= 8'd20, e <= 8'd10);
      chk("idle delta", 16'h0000, {8'h0, delta_out[15:8]});
      chk("base view", 16'hFFFF >> ((i > BASE_SHIFT_MAX) ? BASE_SHIFT_MAX : i), base_view[15:0]);
    end
    raw_delta[15:0] = 16'h7000;
    active_en = 2'b00;
    sense(8'h00, 1'b0, 1'b0);
    active_en = 2'b01;
    sense(8'h7F, 1'b1, 1'b0);
    $display("done: gain and base");
    raw_delta[15:0] = 16'h0400;
    wr(ADDR_SENS, 8'h60);
    wr(ADDR_CFG, 8'h20);
    sense(8'h10, 1'b0, 1'b1);
    wr(ADDR_SENS, 8'h50);
    sense(8'h20, 1'b1, 1'b0);
    lf_noise = 2'b01;
    sense(8'h00, 1'b0, 1'b1);
    wr(ADDR_CFG, 8'h30);
    sense(8'h20, 1'b1, 1'b0);
    lf_noise = 2'b00;
    hold_expired = 2'b01;
    repeat (3) @(negedge clk);
    chk("restart", 16'h0000, {15'h0, recal_restart[0]});
    wr(ADDR_CFG, 8'h38);
    chk("restart", 16'h0001, {15'h0, recal_restart[0]});
    hold_expired = 2'b00;
    $display("done: datapath controls");
    pulses = 0;
    u_host.park(1'b1, 100);
    u_host.park(1'b0, 260);
    chk("resets off", 16'h0000, pulses[15:0]);
    wr(ADDR_CFG, 8'h80);
    pulses = 0;
    u_host.park(1'b1, 100);
    chk("idle resets", 16'h0001, pulses[15:0]);
    pulses = 0;
    u_host.park(1'b0, 260);
    chk("low resets", 16'h0001, pulses[15:0]);
    rd(ADDR_CFG, 8'h80);
    $display("done: bus timeout");
    finish_test();
  end
endmodule : tb

//--- tsc_cfg_if.sv
interface tsc_cfg_if;
  logic [2:0] gain_code;
  logic [3:0] base_shift;
  logic digital_noise_gate_off;
  logic analog_noise_filter_off;
  logic hold_limit_recal_on;

  modport src (output gain_code, base_shift, digital_noise_gate_off, analog_noise_filter_off,
               hold_limit_recal_on);
  modport snk (input gain_code, base_shift, digital_noise_gate_off, analog_noise_filter_off,
               hold_limit_recal_on);
endinterface : tsc_cfg_if

//--- tsc_chk_props.sv
module tsc_chk_props
  import tsc_pkg::*;
#(
  parameter int CH = 6,
  parameter int LOW_CYC = LOW_TIMEOUT_CYC,
  parameter int IDLE_CYC = IDLE_RESET_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic [CH*16-1:0] raw_delta,
  input wire logic [CH*16-1:0] base_raw,
  input wire logic [CH-1:0] active_en,
  input wire logic [CH-1:0] lf_noise,
  input wire logic [CH*8-1:0] touch_thresh,
  input wire logic [CH-1:0] hold_expired,
  input wire logic [CH*8-1:0] delta_out,
  input wire logic [CH*16-1:0] base_view,
  input wire logic [CH-1:0] touch,
  input wire logic [CH-1:0] recal_feed,
  input wire logic [CH-1:0] recal_restart,
  input wire logic bus_reset
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // raw pin run lengths, unsynchronised so a few cycles of slack are allowed
  // ----
  int low_cnt;
  int hi_cnt;
  logic signed [15:0] rd0;
  logic signed [7:0] d0;
  assign rd0 = raw_delta[15:0];
  assign d0 = delta_out[7:0];
  always_ff @(posedge clk) begin
    low_cnt <= scl_in ? 0 : low_cnt + 1;
  end
  always_ff @(posedge clk) begin
    hi_cnt <= (scl_in && sda_in) ? hi_cnt + 1 : 0;
  end
  // ----
  // channel 0 stands for all
  // ----
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  chk_idle_channel:
    assert property (!active_en[0] |=> d0 == 8'sh00) else $error("inactive delta not zero");
  chk_sign_kept:
    assert property (rd0 >= 16'sh0000 |=> !d0[7]) else $error("delta sign flipped");
  chk_sat_top:
    assert property (active_en[0] && !lf_noise[0] && rd0 > 16'sh3FFF |=> d0 == 8'sh7F) else $error("no saturation");
  chk_base_scale:
    assert property (base_view[15:0] <= $past(base_raw[15:0])) else $error("base view grew");
  chk_base_floor:
    assert property (base_view[15:0] >= ($past(base_raw[15:0]) >> BASE_SHIFT_MAX)) else $error("base view over 256x");
  chk_touch_thresh:
    assert property ($past(touch_thresh[7:0]) != 8'h00 |-> touch[0] == (d0 >= $signed($past(touch_thresh[7:0]))))
      else $error("touch against threshold wrong");
  chk_feed_touch:
    assert property (touch[0] |-> !recal_feed[0]) else $error("touched sample fed");
  chk_feed_active:
    assert property (recal_feed[0] |-> $past(active_en[0])) else $error("inactive sample fed");
  chk_restart_cause:
    assert property (recal_restart[0] |-> touch[0] && $past(hold_expired[0])) else $error("restart without cause");
  chk_reset_cause:
    assert property (bus_reset |-> $past(low_cnt, 6) >= LOW_CYC - 8 || $past(hi_cnt, 6) >= IDLE_CYC - 8)
      else $error("bus reset too early");
  chk_reset_pulse:
    assert property (bus_reset |=> !bus_reset) else $error("bus reset not a pulse");
endmodule : tsc_chk_props

bind tsc_top tsc_chk_props #(.CH(CH), .LOW_CYC(LOW_CYC), .IDLE_CYC(IDLE_CYC)) u_chk (
  .clk(clk), .nrst(nrst), .scl_in(scl_in), .sda_in(sda_in), .raw_delta(raw_delta), .base_raw(base_raw),
  .active_en(active_en), .lf_noise(lf_noise), .touch_thresh(touch_thresh), .hold_expired(hold_expired),
  .delta_out(delta_out), .base_view(base_view), .touch(touch), .recal_feed(recal_feed),
  .recal_restart(recal_restart), .bus_reset(bus_reset)
);

//--- tsc_host.sv
module tsc_host
  import tsc_pkg::*;
#(
  parameter int H = 10,
  parameter logic [6:0] DEV = DEV_ADDR_DEFAULT
) (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_drv
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // line primitives, half period H clocks
  // ----
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic half();
    repeat (H) @(negedge clk);
  endtask : half
  task automatic start();
    @(negedge clk);
    sda_drv = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_drv = 1'b0;
    half();
    scl = 1'b0;
  endtask : start
  task automatic stop();
    @(negedge clk);
    sda_drv = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_drv = 1'b1;
    half();
  endtask : stop
  // data moves a clock after scl falls, so the slave never sees a false start
  task automatic xfer(input logic b, output logic s);
    @(negedge clk);
    sda_drv = b;
    half();
    scl = 1'b1;
    half();
    s = sda_line;
    scl = 1'b0;
  endtask : xfer
  // sends b msb first; ninth bit released, so reads end with a nack
  task automatic octet(input logic [7:0] b, output logic [7:0] r, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      xfer(b[i], r[i]);
    end
    xfer(1'b1, s);
    ack = !s;
  endtask : octet
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic k0;
    logic k1;
    logic k2;
    start();
    octet({DEV, 1'b0}, r, k0);
    octet(a, r, k1);
    octet(d, r, k2);
    stop();
    ok = k0 & k1 & k2;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic k0;
    logic k1;
    logic k2;
    logic k3;
    start();
    octet({DEV, 1'b0}, r, k0);
    octet(a, r, k1);
    start();
    octet({DEV, 1'b1}, r, k2);
    octet(8'hFF, d, k3);
    stop();
    ok = k0 & k1 & k2;
  endtask : rd_reg
  task automatic park(input logic lvl, input int n);
    scl = lvl;
    repeat (n) @(negedge clk);
    scl = 1'b1;
  endtask : park
endmodule : tsc_host

//--- tsc_pkg.sv
package tsc_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int LOW_TIMEOUT_MS = 30;
  localparam int LOW_TIMEOUT_CYC = LOW_TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int IDLE_RESET_US = 200;
  localparam int IDLE_RESET_CYC = IDLE_RESET_US * CLK_MHZ;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_SENS = 8'h1F;
  localparam logic [7:0] ADDR_CFG = 8'h20;
  localparam logic [7:0] ADDR_CFG2 = 8'h44;
  localparam logic [7:0] RST_SENS = 8'h2F;
  localparam logic [7:0] RST_CFG = 8'h20;
  localparam logic [7:0] RST_CFG2 = 8'h40;
  localparam logic [7:0] MASK_SENS = 8'h7F;
  localparam logic [7:0] MASK_CFG = 8'hB8;
  localparam logic [7:0] MASK_CFG2 = 8'h7F;

  // field positions
  localparam int GAIN_LSB = 4;
  localparam int BASE_LSB = 0;
  localparam int TIMEOUT_BIT = 7;
  localparam int DIG_GATE_BIT = 5;
  localparam int ANA_FILT_BIT = 4;
  localparam int HOLD_RECAL_BIT = 3;
  // baseline scale tops out at 256x, every higher code repeats it
  localparam logic [3:0] BASE_SHIFT_MAX = 4'h8;

  // slave address on the serial bus, plain default
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h28;
  localparam logic [7:0] IDLE_BYTE = 8'h00;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h2,
    ST_PTR = 4'h3,
    ST_PTR_ACK = 4'h4,
    ST_WDATA = 4'h5,
    ST_WDATA_ACK = 4'h6,
    ST_RDATA = 4'h7,
    ST_RDATA_ACK = 4'h8
  } tsc_bus_state_type;

  // gain code n shifts the raw count right by n: 000b keeps full weight (128x), 111b is 1x
  function automatic logic signed [7:0] tsc_scale_sat(input logic signed [15:0] raw, input logic [3:0] sh);
    logic signed [15:0] s;
    s = raw >>> sh;
    if (s > 16'sd127) begin
      tsc_scale_sat = 8'sh7F;
    end else if (s < -16'sd128) begin
      tsc_scale_sat = 8'sh80;
    end else begin
      tsc_scale_sat = s[7:0];
    end
  endfunction : tsc_scale_sat

  function automatic logic [7:0] tsc_read_map(input logic [7:0] a, input logic [7:0] s, input logic [7:0] c,
                                              input logic [7:0] c2);
    case (a)
      ADDR_SENS: tsc_read_map = s;
      ADDR_CFG: tsc_read_map = c;
      ADDR_CFG2: tsc_read_map = c2;
      default: tsc_read_map = IDLE_BYTE;
    endcase
  endfunction : tsc_read_map

endpackage : tsc_pkg

//--- tsc_sense.sv
module tsc_sense
  import tsc_pkg::*;
#(
  parameter int CH = 6
) (
  input wire logic clk,
  input wire logic nrst,
  tsc_cfg_if.snk cfg,
  input wire logic [CH*16-1:0] raw_delta,
  input wire logic [CH*16-1:0] base_raw,
  input wire logic [CH-1:0] active_en,
  input wire logic [CH-1:0] lf_noise,
  input wire logic [CH*8-1:0] touch_thresh,
  input wire logic [7:0] noise_thresh,
  input wire logic [CH-1:0] hold_expired,
  output logic [CH*8-1:0] delta_reg,
  output logic [CH*16-1:0] base_view_reg,
  output logic [CH-1:0] touch_reg,
  output logic [CH-1:0] recal_feed_reg,
  output logic [CH-1:0] recal_restart_reg
);

  // ---------------------------------------------------------------
  // per-channel delta path
  // ---------------------------------------------------------------
  logic signed [7:0] d_next [CH];
  logic [CH-1:0] touch_next;
  logic [CH-1:0] feed_next;

  always_comb begin
    for (int i = 0; i < CH; i++) begin
      d_next[i] = tsc_scale_sat(raw_delta[i*16 +: 16], {1'b0, cfg.gain_code});
      if (!active_en[i]) begin
        d_next[i] = 8'sh00;
      end else if (lf_noise[i] && !cfg.analog_noise_filter_off) begin
        d_next[i] = 8'sh00;
      end
      touch_next[i] = d_next[i] >= $signed({1'b0, touch_thresh[i*8 +: 7]}) && !touch_thresh[i*8+7] ? 1'b1 :
                      (d_next[i] >= $signed({1'b0, touch_thresh[i*8 +: 7]}) && touch_thresh[i*8+7] == 1'b0);
      // samples in the noise band are kept out of the baseline tracker only while the gate is on
      if (touch_next[i]) begin
        feed_next[i] = 1'b0;
      end else if (!cfg.digital_noise_gate_off && d_next[i] > $signed({1'b0, noise_thresh[6:0]})) begin
        feed_next[i] = 1'b0;
      end else begin
        feed_next[i] = active_en[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      delta_reg <= '0;
      touch_reg <= '0;
      recal_feed_reg <= '0;
    end else begin
      for (int i = 0; i < CH; i++) begin
        delta_reg[i*8 +: 8] <= d_next[i];
      end
      touch_reg <= touch_next;
      recal_feed_reg <= feed_next;
    end
  end

  // ---------------------------------------------------------------
  // hold limit and baseline presentation
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      recal_restart_reg <= '0;
    end else begin
      recal_restart_reg <= touch_next & hold_expired & {CH{cfg.hold_limit_recal_on}};
    end
  end

  // presentation only: nothing in the touch path reads this shift
  logic [3:0] base_sh;
  assign base_sh = (cfg.base_shift > BASE_SHIFT_MAX) ? BASE_SHIFT_MAX : cfg.base_shift;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      base_view_reg <= '0;
    end else begin
      for (int i = 0; i < CH; i++) begin
        base_view_reg[i*16 +: 16] <= base_raw[i*16 +: 16] >> base_sh;
      end
    end
  end

endmodule : tsc_sense

//--- tsc_top.sv
// Behaviour
// - gain code 000b scales deltas by 128x, each step halves it down to 1x at 111b, reset code 010b is 32x.
// - the gain code in bits 6 to 4 scales every Active-enabled input's delta before threshold comparison.
// - the four-bit baseline field sets a power-of-two presentation scale from 1x to 256x, reset 1111b.
// - the baseline field changes only the presented baseline, never touch decisions or sensitivity.
// - with bit 7 set the serial interface resets when the clock line stays low beyond 30 ms.
// - with bit 7 set the serial interface also resets when both lines stay high beyond 200 us.
// - with bit 7 clear, its reset state, neither the low-clock timeout nor the idle reset happens.
// - with the digital gate on, a delta above the noise threshold but below touch is kept from recalibration.
// - with the digital gate off, its reset state, every Active-enabled input's delta below touch feeds recalibration.
// - bit 4 of the main configuration register turns the analog noise filter off when set.
// - with the analog filter on, reported low-frequency noise zeroes that channel's delta; off, it is ignored.
// - with hold-limit enabled, a touch held past its maximum duration restarts recalibration.
module tsc_top
  import tsc_pkg::*;
#(
  parameter int CH = 6,
  parameter int LOW_CYC = LOW_TIMEOUT_CYC,
  parameter int IDLE_CYC = IDLE_RESET_CYC,
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic [CH*16-1:0] raw_delta,
  input wire logic [CH*16-1:0] base_raw,
  input wire logic [CH-1:0] active_en,
  input wire logic [CH-1:0] lf_noise,
  input wire logic [CH*8-1:0] touch_thresh,
  input wire logic [7:0] noise_thresh,
  input wire logic [CH-1:0] hold_expired,
  output logic [CH*8-1:0] delta_out,
  output logic [CH*16-1:0] base_view,
  output logic [CH-1:0] touch,
  output logic [CH-1:0] recal_feed,
  output logic [CH-1:0] recal_restart,
  output logic bus_reset
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic scl_d_reg;
  logic sda_d_reg;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      scl_d_reg <= scl_sync_reg[1];
      sda_d_reg <= sda_sync_reg[1];
    end
  end

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  assign scl_s = scl_sync_reg[1];
  assign sda_s = sda_sync_reg[1];
  assign scl_rise = scl_s && !scl_d_reg;
  assign scl_fall = !scl_s && scl_d_reg;
  assign start_cond = scl_s && scl_d_reg && !sda_s && sda_d_reg;
  assign stop_cond = scl_s && scl_d_reg && sda_s && !sda_d_reg;

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  logic [7:0] sens_reg;
  logic [7:0] cfg_reg;
  logic [7:0] cfg2_reg;
  logic [7:0] ptr_reg;
  logic [7:0] shift_reg;
  logic [3:0] bitcnt_reg;
  tsc_bus_state_type state_reg;
  logic wr_fire;

  assign wr_fire = scl_fall && state_reg == ST_WDATA && bitcnt_reg == 4'h8;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sens_reg <= RST_SENS;
      cfg_reg <= RST_CFG;
      cfg2_reg <= RST_CFG2;
    end else if (wr_fire) begin
      case (ptr_reg)
        ADDR_SENS: sens_reg <= shift_reg & MASK_SENS;
        ADDR_CFG: cfg_reg <= shift_reg & MASK_CFG;
        ADDR_CFG2: cfg2_reg <= shift_reg & MASK_CFG2;
        default: sens_reg <= sens_reg;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // bus timeout and idle reset
  // ---------------------------------------------------------------
  logic [31:0] low_cnt_reg;
  logic [31:0] idle_cnt_reg;
  logic bus_rst;
  logic timeout_on;

  assign timeout_on = cfg_reg[TIMEOUT_BIT];
  // counters saturate so a long stuck bus fires once, not repeatedly
  assign bus_rst = timeout_on && (low_cnt_reg == 32'(LOW_CYC) || idle_cnt_reg == 32'(IDLE_CYC));

  always_ff @(posedge clk) begin
    if (!nrst) begin
      low_cnt_reg <= '0;
      idle_cnt_reg <= '0;
    end else begin
      if (!timeout_on || scl_s) begin
        low_cnt_reg <= '0;
      end else if (low_cnt_reg <= 32'(LOW_CYC)) begin
        low_cnt_reg <= low_cnt_reg + 32'h1;
      end
      if (!timeout_on || !scl_s || !sda_s) begin
        idle_cnt_reg <= '0;
      end else if (idle_cnt_reg <= 32'(IDLE_CYC)) begin
        idle_cnt_reg <= idle_cnt_reg + 32'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      bus_reset <= 1'b0;
    end else begin
      bus_reset <= bus_rst;
    end
  end

  // ---------------------------------------------------------------
  // serial slave engine
  // ---------------------------------------------------------------
  logic rw_reg;
  logic nack_reg;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      bitcnt_reg <= '0;
      shift_reg <= '0;
      ptr_reg <= '0;
      rw_reg <= 1'b0;
      nack_reg <= 1'b0;
      sda_oe_n <= 1'b1;
    end else if (bus_rst || stop_cond) begin
      state_reg <= ST_IDLE;
      sda_oe_n <= 1'b1;
    end else if (start_cond) begin
      state_reg <= ST_ADDR;
      bitcnt_reg <= '0;
      sda_oe_n <= 1'b1;
    end else begin
      case (state_reg)
        ST_ADDR, ST_PTR, ST_WDATA: begin
          if (scl_rise && bitcnt_reg != 4'h8) begin
            shift_reg <= {shift_reg[6:0], sda_s};
            bitcnt_reg <= bitcnt_reg + 4'h1;
          end else if (scl_fall && bitcnt_reg == 4'h8) begin
            bitcnt_reg <= '0;
            sda_oe_n <= 1'b0;
            if (state_reg == ST_ADDR) begin
              if (shift_reg[7:1] == DEV_ADDR) begin
                rw_reg <= shift_reg[0];
                state_reg <= ST_ADDR_ACK;
              end else begin
                sda_oe_n <= 1'b1;
                state_reg <= ST_IDLE;
              end
            end else if (state_reg == ST_PTR) begin
              ptr_reg <= shift_reg;
              state_reg <= ST_PTR_ACK;
            end else begin
              ptr_reg <= ptr_reg + 8'h1;
              state_reg <= ST_WDATA_ACK;
            end
          end
        end
        ST_ADDR_ACK, ST_PTR_ACK, ST_WDATA_ACK: begin
          if (scl_fall) begin
            if (state_reg == ST_ADDR_ACK && rw_reg) begin
              shift_reg <= tsc_read_map(ptr_reg, sens_reg, cfg_reg, cfg2_reg);
              sda_oe_n <= tsc_read_map(ptr_reg, sens_reg, cfg_reg, cfg2_reg) >> 7 != 8'h0;
              ptr_reg <= ptr_reg + 8'h1;
              state_reg <= ST_RDATA;
            end else begin
              sda_oe_n <= 1'b1;
              state_reg <= state_reg == ST_ADDR_ACK ? ST_PTR : ST_WDATA;
            end
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (bitcnt_reg == 4'h7) begin
              bitcnt_reg <= '0;
              sda_oe_n <= 1'b1;
              state_reg <= ST_RDATA_ACK;
            end else begin
              bitcnt_reg <= bitcnt_reg + 4'h1;
              shift_reg <= {shift_reg[6:0], 1'b0};
              sda_oe_n <= shift_reg[6];
            end
          end
        end
        ST_RDATA_ACK: begin
          if (scl_rise) begin
            nack_reg <= sda_s;
          end else if (scl_fall) begin
            if (nack_reg) begin
              state_reg <= ST_IDLE;
            end else begin
              shift_reg <= tsc_read_map(ptr_reg, sens_reg, cfg_reg, cfg2_reg);
              sda_oe_n <= tsc_read_map(ptr_reg, sens_reg, cfg_reg, cfg2_reg) >> 7 != 8'h0;
              ptr_reg <= ptr_reg + 8'h1;
              state_reg <= ST_RDATA;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // open drain: the line is only ever pulled low
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // sensing datapath
  // ---------------------------------------------------------------
  tsc_cfg_if cfg_bus ();

  assign cfg_bus.gain_code = sens_reg[GAIN_LSB +: 3];
  assign cfg_bus.base_shift = sens_reg[BASE_LSB +: 4];
  assign cfg_bus.digital_noise_gate_off = cfg_reg[DIG_GATE_BIT];
  assign cfg_bus.analog_noise_filter_off = cfg_reg[ANA_FILT_BIT];
  assign cfg_bus.hold_limit_recal_on = cfg_reg[HOLD_RECAL_BIT];

  tsc_sense #(
    .CH(CH)
  ) u_sense (
    .clk(clk),
    .nrst(nrst),
    .cfg(cfg_bus.snk),
    .raw_delta(raw_delta),
    .base_raw(base_raw),
    .active_en(active_en),
    .lf_noise(lf_noise),
    .touch_thresh(touch_thresh),
    .noise_thresh(noise_thresh),
    .hold_expired(hold_expired),
    .delta_reg(delta_out),
    .base_view_reg(base_view),
    .touch_reg(touch),
    .recal_feed_reg(recal_feed),
    .recal_restart_reg(recal_restart)
  );

endmodule : tsc_top
